// ---- hw/aes_block_coprocessor.sv ----
// apb register front end and block sequencer of the aes coprocessor
`timescale 1ns/1ns
`include "aes_cop_params.svh"
// ----------------------------------------
// What this block does
// RULE1: whole 128-bit block in, transform, read out
// RULE2: host writes start before each block
// RULE3: key kept until next key load
// RULE4: host loads iv once per message
// RULE5: reset clears key and iv
// RULE6: host selects load command, mode with iv
// RULE7: key or iv load aborts running work
// RULE8: host zero-pads a short last block
// RULE9: control, input and output byte registers
// RULE10: feedback modes move four 32-bit parts
// RULE11: dma triggers pace each 32-bit part
// RULE12: host sets up both dma channels first
// RULE13: start raises the input dma trigger
// RULE14: completion pulse after every block
// RULE15: last block in cbc gives the mac
// RULE16: host compares mac to check it
// RULE17: ecb cbc cfb ofb ctr cbc-mac, 128-bit key
// RULE18: host builds first authentication block
// RULE19: host sets authentication flag fields
// RULE20: host prefixes associated data length
// RULE21: host keeps upper m bytes as tag
// RULE22: host builds counter first block
// RULE23: command codes run on start bit
// RULE24: start self clears, ready bit status
// RULE25: three-bit mode field encodings
// RULE26: input and output dma request triggers
// RULE27: bytes move in order, first byte first
// ----------------------------------------
module aes_block_coprocessor
  import aes_cop_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic INPUT_DMA_REQUEST_OUT,
  output logic OUTPUT_DMA_REQUEST_OUT,
  output logic BLOCK_DONE_OUT
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [2:0] mode_q;
  logic [1:0] cmd_q;
  logic st_q;
  phase_e phase_q;
  phase_e phase_d;
  logic [3:0] cnt_q;
  logic [3:0] ocnt_q;
  block_t in_blk_q;
  block_t out_blk_q;
  block_t ks_q;
  block_t key_q;
  block_t dkey_q;
  block_t iv_q;
  block_t iv_d;
  byte_t din_q;
  logic [31:0] prdata_q;
  logic eng_go_q;
  logic in_req_q;
  logic out_req_q;
  logic done_q;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic setup;
  logic access;
  logic hit_ctl;
  logic hit_in;
  logic hit_out;
  logic wr_ctl;
  logic wr_in;
  logic rd_out;
  logic start;
  byte_t ctl_rd;
  logic [31:0] rdata;

  assign setup = PSEL_IN & ~PENABLE_IN;
  assign access = PSEL_IN & PENABLE_IN;
  assign hit_ctl = PADDR_IN == {`IDX_CTRL, 2'b00}; // RULE9
  assign hit_in = PADDR_IN == {`IDX_INPUT, 2'b00}; // RULE9
  assign hit_out = PADDR_IN == {`IDX_OUTPUT, 2'b00}; // RULE9
  assign wr_ctl = access & PWRITE_IN & hit_ctl;
  assign wr_in = access & PWRITE_IN & hit_in;
  assign rd_out = access & ~PWRITE_IN & hit_out;
  assign start = wr_ctl & PWDATA_IN[`CTL_ST]; // RULE23

  // ----------------------------------------
  // mode and command qualifiers
  // ----------------------------------------
  logic seg;
  logic chain;
  logic inv_op;
  logic is_key;
  logic is_iv;
  logic in_take;
  logic out_take;
  logic in_last;
  logic run_done;
  logic blk_done;
  logic go;
  logic enter_in;
  logic enter_out;

  // feedback modes split the block into four 32-bit parts
  assign seg = ~cmd_q[1] & (mode_q == `MODE_CFB | mode_q == `MODE_OFB | mode_q == `MODE_CTR); // RULE10
  assign chain = mode_q == `MODE_CBC | mode_q == `MODE_CMAC;
  // cbc-mac runs the forward cipher for both commands
  assign inv_op = cmd_q == `CMD_DEC & (mode_q == `MODE_ECB | mode_q == `MODE_CBC); // RULE17
  assign is_key = cmd_q == `CMD_KEY;
  assign is_iv = cmd_q == `CMD_IV;
  assign in_take = wr_in & phase_q == PH_IN;
  assign out_take = rd_out & phase_q == PH_OUT;
  assign in_last = cnt_q == `LAST_BYTE;

  // ----------------------------------------
  // engine
  // ----------------------------------------
  logic eng_done;
  block_t eng_res;
  block_t eng_lastkey;
  block_t eng_blk;
  eng_op_e eng_op;
  block_t ks_xor;
  block_t out_word;
  byte_t out_byte;
  block_t full_in;

  assign full_in = {in_blk_q[127:8], PWDATA_IN[7:0]};
  assign eng_blk = seg ? iv_q : ((chain & ~inv_op) ? in_blk_q ^ iv_q : in_blk_q);
  assign eng_op = is_key ? OP_EXPAND : (inv_op ? OP_DEC : OP_ENC);
  assign run_done = phase_q == PH_RUN & eng_done;

  aes_round_engine u_engine (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .abort_in(start), // RULE7
    .start_in(eng_go_q),
    .op_in(eng_op),
    .key_in(key_q),
    .dkey_in(dkey_q),
    .blk_in(eng_blk),
    .done_out(eng_done),
    .result_out(eng_res),
    .lastkey_out(eng_lastkey)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    phase_d = phase_q;
    go = 1'b0;
    enter_in = 1'b0;
    enter_out = 1'b0;
    blk_done = 1'b0;
    if (start) begin
      // any new start drops the current block, so a load also aborts
      phase_d = PH_IN; // RULE7
      enter_in = 1'b1; // RULE13
    end else begin
      case (phase_q)
        PH_IDLE: begin
          phase_d = PH_IDLE;
        end
        PH_IN: begin
          if (in_take) begin
            if (cmd_q[1] & in_last) begin
              phase_d = is_key ? PH_RUN : PH_IDLE;
              go = is_key;
            end else if (seg & cnt_q == `FIRST_SEG_END) begin
              phase_d = PH_RUN;
              go = 1'b1;
            end else if (seg & cnt_q[1:0] == `SEG_LAST) begin
              phase_d = PH_OUT; // RULE10
              enter_out = 1'b1; // RULE11
            end else if (~cmd_q[1] & ~seg & in_last) begin
              phase_d = PH_RUN; // RULE1
              go = 1'b1;
            end
          end
        end
        PH_RUN: begin
          if (eng_done) begin
            phase_d = is_key ? PH_IDLE : PH_OUT;
            enter_out = ~is_key; // RULE26
          end
        end
        PH_OUT: begin
          if (out_take) begin
            if (ocnt_q == `LAST_BYTE) begin
              phase_d = PH_IDLE;
              blk_done = 1'b1; // RULE14
            end else if (seg & ocnt_q[1:0] == `SEG_LAST) begin
              phase_d = PH_IN;
              enter_in = 1'b1; // RULE11
            end
          end
        end
        default: begin
          phase_d = PH_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // chaining value
  // ----------------------------------------
  assign ks_xor = in_blk_q ^ ks_q;

  always_comb begin
    iv_d = iv_q;
    if (in_take & is_iv & in_last) begin
      iv_d = full_in; // RULE4
    end else if (run_done & chain & ~cmd_q[1]) begin
      iv_d = inv_op ? in_blk_q : eng_res; // RULE15
    end else if (blk_done & seg) begin
      case (mode_q)
        `MODE_OFB: iv_d = ks_q;
        `MODE_CFB: iv_d = cmd_q == `CMD_DEC ? in_blk_q : ks_xor;
        `MODE_CTR: iv_d = {iv_q[127:32], iv_q[31:0] + 32'h0000_0001};
        default: iv_d = iv_q;
      endcase
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // feedback modes xor on the fly, so each part after the first is ready as soon as it is in; the first waits for the engine run
  assign out_word = seg ? ks_xor : out_blk_q;
  assign out_byte = out_word[{~ocnt_q, 3'b000} +: 8]; // RULE27
  assign ctl_rd = {1'b0, mode_q, phase_q == PH_IDLE, cmd_q, st_q}; // RULE24
  assign rdata = hit_ctl ? {24'h00_0000, ctl_rd}
               : hit_in ? {24'h00_0000, din_q}
               : hit_out ? {24'h00_0000, out_byte} : 32'h0000_0000;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      mode_q <= `MODE_RESET;
      cmd_q <= `CMD_RESET;
      st_q <= 1'b0;
      din_q <= 8'h00;
    end else begin
      if (wr_ctl) begin
        mode_q <= PWDATA_IN[`CTL_MODE_HI:`CTL_MODE_LO]; // RULE25
        cmd_q <= PWDATA_IN[`CTL_CMD_HI:`CTL_CMD_LO]; // RULE23
      end
      // processing begins on the edge that sets start, and the next edge clears it
      st_q <= start; // RULE24
      if (wr_in) begin
        din_q <= PWDATA_IN[7:0];
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      phase_q <= PH_IDLE;
      cnt_q <= 4'h0;
      ocnt_q <= 4'h0;
    end else begin
      phase_q <= phase_d;
      if (start) begin
        cnt_q <= 4'h0;
      end else if (in_take) begin
        cnt_q <= cnt_q + 4'h1; // RULE27
      end
      if (start) begin
        ocnt_q <= 4'h0;
      end else if (out_take) begin
        ocnt_q <= ocnt_q + 4'h1; // RULE27
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      in_blk_q <= '0;
      out_blk_q <= '0;
      ks_q <= '0;
    end else begin
      if (in_take) begin
        in_blk_q[{~cnt_q, 3'b000} +: 8] <= PWDATA_IN[7:0]; // RULE27
      end
      if (run_done & seg) begin
        ks_q <= eng_res;
      end
      if (run_done & ~seg & ~cmd_q[1]) begin
        out_blk_q <= (inv_op & mode_q == `MODE_CBC) ? eng_res ^ iv_q : eng_res;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      key_q <= '0; // RULE5
      dkey_q <= '0;
      iv_q <= '0; // RULE5
    end else begin
      if (in_take & is_key & in_last) begin
        key_q <= full_in; // RULE3
      end
      if (run_done & is_key) begin
        dkey_q <= eng_lastkey;
      end
      iv_q <= iv_d;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      eng_go_q <= 1'b0;
      in_req_q <= 1'b0;
      out_req_q <= 1'b0;
      done_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      eng_go_q <= go;
      in_req_q <= enter_in; // RULE26
      out_req_q <= enter_out; // RULE26
      done_q <= blk_done;
      if (setup) begin
        prdata_q <= rdata;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = access & ~(hit_ctl | hit_in | hit_out);
  assign INPUT_DMA_REQUEST_OUT = in_req_q;
  assign OUTPUT_DMA_REQUEST_OUT = out_req_q;
  assign BLOCK_DONE_OUT = done_q;
endmodule : aes_block_coprocessor

// ---- hw/aes_cop_params.svh ----
// register indices, field positions and encodings of the aes coprocessor
`ifndef AES_COP_PARAMS_SVH
`define AES_COP_PARAMS_SVH
`define IDX_INPUT 10'h0B1
`define IDX_OUTPUT 10'h0B2
`define IDX_CTRL 10'h0B3
`define CTL_MODE_HI 6
`define CTL_MODE_LO 4
`define CTL_CMD_HI 2
`define CTL_CMD_LO 1
`define CTL_ST 0
`define MODE_RESET 3'h0
`define CMD_RESET 2'h0
`define MODE_CBC 3'h0
`define MODE_CFB 3'h1
`define MODE_OFB 3'h2
`define MODE_CTR 3'h3
`define MODE_ECB 3'h4
`define MODE_CMAC 3'h5
`define CMD_ENC 2'h0
`define CMD_DEC 2'h1
`define CMD_KEY 2'h2
`define CMD_IV 2'h3
`define LAST_BYTE 4'hF
`define SEG_LAST 2'h3
`define FIRST_SEG_END 4'h3
`define ROUNDS 4'hA
`define RCON_FIRST 8'h01
`define RCON_LAST 8'h36
`define RCON_BACK 8'h8D
`define GF_POLY 8'h1B
`define AFFINE_C 8'h63
`define INV_AFFINE_C 8'h05
`endif

// ---- hw/aes_cop_pkg.sv ----
// types shared by the aes coprocessor modules
package aes_cop_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [127:0] block_t;
  typedef enum logic [1:0] {PH_IDLE, PH_IN, PH_RUN, PH_OUT} phase_e;
  typedef enum logic [1:0] {OP_ENC, OP_DEC, OP_EXPAND} eng_op_e;
endpackage : aes_cop_pkg

// ---- hw/aes_round_engine.sv ----
// iterative aes-128 engine, one round per clock, key schedule on the fly
`timescale 1ns/1ns
`include "aes_cop_params.svh"
module aes_round_engine
  import aes_cop_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic abort_in,
  input wire logic start_in,
  input wire eng_op_e op_in,
  input wire block_t key_in,
  input wire block_t dkey_in,
  input wire block_t blk_in,
  output logic done_out,
  output block_t result_out,
  output block_t lastkey_out
);
  function automatic byte_t xt(input byte_t b);
    xt = {b[6:0], 1'b0} ^ (b[7] ? `GF_POLY : 8'h00);
  endfunction : xt
  function automatic byte_t gmul(input byte_t a, input byte_t b);
    byte_t p;
    byte_t x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      p = b[i] ? p ^ x : p;
      x = xt(x);
    end
    gmul = p;
  endfunction : gmul
  // inverse as a^254; no table keeps the source short, at a cost in area
  function automatic byte_t ginv(input byte_t a);
    byte_t p;
    byte_t r;
    p = a;
    r = 8'h01;
    for (int i = 1; i < 8; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    ginv = r;
  endfunction : ginv
  function automatic byte_t rl(input byte_t s, input int k);
    logic [15:0] t;
    t = {s, s} << k;
    rl = t[15:8];
  endfunction : rl
  function automatic byte_t sbox(input byte_t b);
    byte_t s;
    s = ginv(b);
    sbox = s ^ rl(s, 1) ^ rl(s, 2) ^ rl(s, 3) ^ rl(s, 4) ^ `AFFINE_C;
  endfunction : sbox
  function automatic byte_t isbox(input byte_t b);
    isbox = ginv(rl(b, 1) ^ rl(b, 3) ^ rl(b, 6) ^ `INV_AFFINE_C);
  endfunction : isbox
  function automatic block_t sub_sh(input block_t s, input logic inv);
    block_t o;
    int src;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        src = inv ? r + 4 * ((c + 4 - r) % 4) : r + 4 * ((c + r) % 4);
        o[8 * (15 - r - 4 * c) +: 8] = inv ? isbox(s[8 * (15 - src) +: 8]) : sbox(s[8 * (15 - src) +: 8]);
      end
    end
    sub_sh = o;
  endfunction : sub_sh
  function automatic block_t mix(input block_t s, input logic inv);
    block_t o;
    byte_t m[4];
    o = '0;
    m[0] = inv ? 8'h0E : 8'h02;
    m[1] = inv ? 8'h0B : 8'h03;
    m[2] = inv ? 8'h0D : 8'h01;
    m[3] = inv ? 8'h09 : 8'h01;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        for (int j = 0; j < 4; j++) begin
          o[8 * (15 - r - 4 * c) +: 8] ^= gmul(s[8 * (15 - (r + j) % 4 - 4 * c) +: 8], m[j]);
        end
      end
    end
    mix = o;
  endfunction : mix
  function automatic logic [31:0] subw(input logic [31:0] w, input byte_t rc);
    subw = {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
  endfunction : subw
  function automatic block_t kfwd(input block_t k, input byte_t rc);
    logic [31:0] n0;
    logic [31:0] n1;
    logic [31:0] n2;
    n0 = k[127:96] ^ subw(k[31:0], rc);
    n1 = k[95:64] ^ n0;
    n2 = k[63:32] ^ n1;
    kfwd = {n0, n1, n2, k[31:0] ^ n2};
  endfunction : kfwd
  function automatic block_t kbwd(input block_t k, input byte_t rc);
    logic [31:0] w3;
    w3 = k[31:0] ^ k[63:32];
    kbwd = {k[127:96] ^ subw(w3, rc), k[95:64] ^ k[127:96], k[63:32] ^ k[95:64], w3};
  endfunction : kbwd

  block_t st_q;
  block_t rk_q;
  byte_t rc_q;
  logic [3:0] rnd_q;
  logic busy_q;
  logic done_q;
  eng_op_e op_q;
  block_t rk_next;
  block_t rk_prev;
  block_t enc_sr;
  block_t dec_t;
  block_t st_step;
  block_t st_d;
  block_t rk_d;
  byte_t rc_d;
  logic last_rnd;

  assign last_rnd = rnd_q == `ROUNDS;
  assign rk_next = kfwd(rk_q, rc_q);
  assign rk_prev = kbwd(rk_q, rc_q);
  assign enc_sr = sub_sh(st_q, 1'b0);
  assign dec_t = sub_sh(st_q, 1'b1) ^ rk_prev;
  assign st_step = op_q == OP_DEC ? (last_rnd ? dec_t : mix(dec_t, 1'b1))
                 : (last_rnd ? enc_sr : mix(enc_sr, 1'b0)) ^ rk_next;
  assign st_d = start_in ? blk_in ^ (op_in == OP_DEC ? dkey_in : key_in) : st_step;
  assign rk_d = start_in ? (op_in == OP_DEC ? dkey_in : key_in) : (op_q == OP_DEC ? rk_prev : rk_next);
  assign rc_d = start_in ? (op_in == OP_DEC ? `RCON_LAST : `RCON_FIRST)
              : (op_q == OP_DEC ? ({1'b0, rc_q[7:1]} ^ (rc_q[0] ? `RCON_BACK : 8'h00)) : xt(rc_q));

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= '0;
      rk_q <= '0;
      rc_q <= `RCON_FIRST;
      rnd_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      op_q <= OP_ENC;
    end else begin
      done_q <= busy_q & last_rnd & ~abort_in;
      busy_q <= ~abort_in & (start_in | (busy_q & ~last_rnd));
      if (start_in | busy_q) begin
        st_q <= st_d;
        rk_q <= rk_d;
        rc_q <= rc_d;
        rnd_q <= start_in ? 4'h1 : rnd_q + 4'h1;
      end
      if (start_in) begin
        op_q <= op_in;
      end
    end
  end

  assign done_out = done_q;
  assign result_out = st_q;
  assign lastkey_out = rk_q;
endmodule : aes_round_engine

// ---- verification/aes_host_model.sv ----
// apb master model standing in for the cpu and the two dma channels
`timescale 1ns/1ns
module aes_host_model (
  input wire logic clk_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  // idle cycles before each setup beyond the one always there: 0 is a prompt host, more is a slow one
  int gap = 0;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
  end
  // ----------------------------------------
  // one bus transfer, request held until pready
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    repeat (gap + 1) @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= wd;
    @(posedge clk_in);
    penable_out <= 1'b1;
    @(posedge clk_in);
    // only the bench watchdog ends a wait for pready
    while (pready_in !== 1'b1) begin
      @(posedge clk_in);
    end
    rd = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // released lines must not keep looking valid
    paddr_out <= ~a;
    pwdata_out <= ~wd;
  endtask : xfer
endmodule : aes_host_model

// ---- verification/aes_block_coprocessor_asserts.sv ----
// concurrent checks on the aes coprocessor ports
`timescale 1ns/1ns
`include "aes_cop_params.svh"
module aes_block_coprocessor_asserts (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic INPUT_DMA_REQUEST_OUT,
  input wire logic OUTPUT_DMA_REQUEST_OUT,
  input wire logic BLOCK_DONE_OUT
);
  localparam logic [11:0] a_in = {`IDX_INPUT, 2'b00};
  localparam logic [11:0] a_out = {`IDX_OUTPUT, 2'b00};
  localparam logic [11:0] a_ctl = {`IDX_CTRL, 2'b00};
  logic [7:0] since_q;
  logic [7:0] since_d;
  wire acc = PSEL_IN && PENABLE_IN;
  wire mapped = (PADDR_IN == a_in) || (PADDR_IN == a_out) || (PADDR_IN == a_ctl);
  wire in_wr = acc && PWRITE_IN && (PADDR_IN == a_in);
  wire out_rd = acc && !PWRITE_IN && (PADDR_IN == a_out);
  wire ctl_st = acc && PWRITE_IN && (PADDR_IN == a_ctl) && PWDATA_IN[0];
  // saturating age of the last input write, so a stale request shows up
  assign since_d = in_wr ? 8'h00 : ((since_q == 8'hFF) ? since_q : since_q + 8'h01);
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      since_q <= 8'hFF;
    end else begin
      since_q <= since_d;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  sequence s_start_enc; ctl_st && (PWDATA_IN[2:1] == `CMD_ENC); endsequence
  sequence s_req_gap; ##[1:2] INPUT_DMA_REQUEST_OUT; endsequence
  property p_ready_const; PREADY_OUT; endproperty
  property p_err_unmapped; acc && !mapped |-> PSLVERR_OUT; endproperty
  property p_err_only; PSLVERR_OUT |-> acc && !mapped; endproperty
  property p_read_byte; acc && !PWRITE_IN |-> PRDATA_OUT[31:8] == 24'h00_0000; endproperty
  property p_ctl_bit7; acc && !PWRITE_IN && (PADDR_IN == a_ctl) |-> !PRDATA_OUT[7]; endproperty
  property p_start_req; s_start_enc |-> s_req_gap; endproperty
  property p_in_pulse; INPUT_DMA_REQUEST_OUT |=> !INPUT_DMA_REQUEST_OUT; endproperty
  property p_out_cause; OUTPUT_DMA_REQUEST_OUT |-> since_q <= 8'h14; endproperty
  property p_done_cause; BLOCK_DONE_OUT |-> $past(out_rd, 1) || $past(out_rd, 2); endproperty
  property p_no_done; ctl_st |=> !BLOCK_DONE_OUT [*8]; endproperty
  a_ready_const: assert property (p_ready_const) else $error("pready low");
  a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped");
  a_err_only: assert property (p_err_only) else $error("spurious error");
  a_read_byte: assert property (p_read_byte) else $error("upper read bits set");
  a_ctl_bit7: assert property (p_ctl_bit7) else $error("control bit 7 set");
  a_start_req: assert property (p_start_req) else $error("no input request");
  a_in_pulse: assert property (p_in_pulse) else $error("input request too long");
  a_out_cause: assert property (p_out_cause) else $error("stray output request");
  a_done_cause: assert property (p_done_cause) else $error("done without read");
  a_no_done: assert property (p_no_done) else $error("done after start");
endmodule : aes_block_coprocessor_asserts

bind aes_block_coprocessor aes_block_coprocessor_asserts i_chk (
  .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .INPUT_DMA_REQUEST_OUT(INPUT_DMA_REQUEST_OUT),
  .OUTPUT_DMA_REQUEST_OUT(OUTPUT_DMA_REQUEST_OUT), .BLOCK_DONE_OUT(BLOCK_DONE_OUT)
);

// ---- verification/tb_aes_block_coprocessor.sv ----
// self-checking testbench of the aes coprocessor
`timescale 1ns/1ns
`include "aes_cop_params.svh"
module tb_aes_block_coprocessor
  import aes_cop_pkg::*;
;
  localparam logic [11:0] a_in = {`IDX_INPUT, 2'b00};
  localparam logic [11:0] a_out = {`IDX_OUTPUT, 2'b00};
  localparam logic [11:0] a_ctl = {`IDX_CTRL, 2'b00};
  localparam block_t key_blk = 128'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f;
  localparam block_t pt_blk = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
  localparam block_t ct_blk = 128'h69c4_e0d8_6a7b_0430_d8cd_b780_70b4_c55a;
  localparam block_t zero_ct = 128'h66e9_4bd4_ef8a_2c3b_884c_fa59_ca34_2b2e;
  localparam block_t a0_blk = 128'h05A0_A1A2_A3A4_A5A6_A7A8_0000_0000_0000;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, in_req, out_req, done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e;
  block_t got, tag;
  int miscompares = 0;
  int check_count = 0;
  int in_cnt = 0, out_cnt = 0, done_cnt = 0;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  aes_block_coprocessor i_dut (.CLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .INPUT_DMA_REQUEST_OUT(in_req), .OUTPUT_DMA_REQUEST_OUT(out_req),
    .BLOCK_DONE_OUT(done));
  aes_host_model i_host (.clk_in(clk), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));
  always @(posedge clk) begin
    if (in_req === 1'b1) in_cnt++;
    if (out_req === 1'b1) out_cnt++;
    if (done === 1'b1) done_cnt++;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    i_host.xfer(1'b1, a, {24'h00_0000, d}, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    i_host.xfer(1'b0, a, 32'h0000_0000, r, e);
  endtask : rd
  // pulses are counted by the monitor; wait is bounded so a lost pulse fails
  task automatic wait_cnt(input int sel, input int target);
    int n;
    n = 0;
    while (((sel == 0) ? in_cnt : (sel == 1) ? out_cnt : done_cnt) < target && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("pulse seen", {31'h0, n < 300}, 32'h0000_0001);
  endtask : wait_cnt
  task automatic load(input logic [7:0] ctl, input block_t b);
    int n;
    n = 0;
    wr(a_ctl, ctl);
    for (int k = 0; k < 16; k++) wr(a_in, b[127 - 8 * k -: 8]);
    do begin
      rd(a_ctl);
      n++;
    end while (r[3] !== 1'b1 && n < 40);
    check("ready after load", {31'h0, r[3]}, 32'h0000_0001);
  endtask : load
  task automatic blk(input logic [7:0] ctl, input block_t din, input block_t dexp, input int parts, input bit chk);
    int n, k, ti, to, td;
    n = 16 / parts;
    ti = in_cnt + 1;
    td = done_cnt + 1;
    wr(a_ctl, ctl);
    rd(a_ctl);
    check("ready while busy", {31'h0, r[3]}, 32'h0000_0000);
    for (int p = 0; p < parts; p++) begin
      wait_cnt(0, ti);
      to = out_cnt + 1;
      for (int b = 0; b < n; b++) wr(a_in, din[127 - 8 * (p * n + b) -: 8]);
      wait_cnt(1, to);
      ti = in_cnt + 1;
      for (int b = 0; b < n; b++) begin
        k = p * n + b;
        rd(a_out);
        got[127 - 8 * k -: 8] = r[7:0];
        if (chk) check("output byte", r, {24'h00_0000, dexp[127 - 8 * k -: 8]});
      end
    end
    wait_cnt(2, td);
  endtask : blk
  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
  endtask : do_reset
  task automatic results();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    #400000;
    miscompares++;
    $display("[ERR] watchdog expected end seen timeout");
    results();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(a_ctl);
    check("control reset", r, 32'h0000_0008);
    rd(a_out);
    check("output reset", r, 32'h0000_0000);
    rd(12'h2D0);
    check("unmapped error", {31'h0, e}, 32'h0000_0001);
    blk(8'h41, '0, zero_ct, 1, 1'b1);
    $display("test reset key done");
    load(8'h05, key_blk);
    i_host.gap = 3;
    repeat (2) blk(8'h41, pt_blk, ct_blk, 1, 1'b1);
    i_host.gap = 0;
    blk(8'h43, ct_blk, pt_blk, 1, 1'b1);
    rd(a_in);
    check("input readback", r, 32'h0000_005A);
    $display("test ecb done");
    wr(a_ctl, 8'h41);
    for (int k = 0; k < 16; k++) wr(a_in, 8'h5A);
    load(8'h05, key_blk);
    blk(8'h41, pt_blk, ct_blk, 1, 1'b1);
    $display("test abort done");
    load(8'h07, '0);
    blk(8'h01, pt_blk, ct_blk, 1, 1'b1);
    blk(8'h01, ct_blk ^ pt_blk, ct_blk, 1, 1'b1);
    $display("test cbc done");
    load(8'h57, '0);
    blk(8'h51, pt_blk, '0, 1, 1'b0);
    blk(8'h01, ct_blk ^ pt_blk, ct_blk, 1, 1'b1);
    $display("test mac done");
    load(8'h07, '0);
    blk(8'h51, 128'h1DA0_A1A2_A3A4_A5A6_A7A8_0000_0000_0010, '0, 1, 1'b0);
    blk(8'h01, pt_blk, '0, 1, 1'b0);
    tag = {got[127:64], 64'h0000_0000_0000_0000};
    load(8'h27, a0_blk);
    blk(8'h21, tag, '0, 4, 1'b0);
    load(8'h27, a0_blk);
    blk(8'h21, got, tag, 4, 1'b1);
    $display("test ccm tag done");
    do_reset();
    rd(a_ctl);
    check("control after reset", r, 32'h0000_0008);
    for (logic [2:0] m = `MODE_CFB; m <= `MODE_CTR; m++) begin
      load({1'b0, m, 4'h7}, '0);
      blk({1'b0, m, 4'h1}, '0, zero_ct, 4, 1'b1);
    end
    load(8'h17, '0);
    blk(8'h13, pt_blk, pt_blk ^ zero_ct, 4, 1'b1);
    $display("test feedback modes done");
    results();
  end
endmodule : tb_aes_block_coprocessor
